// file: hw/flash_ctl_params.svh
// Offsets, field positions, reset values and timing counts of the
// nonvolatile array controller. Definitions only.
`ifndef FLASH_CTL_PARAMS_SVH
`define FLASH_CTL_PARAMS_SVH

// Register byte addresses on the APB
`define FL_OFS_CONTROL 8'h00
`define FL_OFS_PROTECT 8'h04
`define FL_OFS_STATUS 8'h08
`define FL_OFS_TARGET 8'h0C

// Control register fields
`define FL_BIT_PROGRAM 0
`define FL_BIT_ERASE 1
`define FL_BIT_WHOLE 2
`define FL_BIT_HV 3
`define FL_CONTROL_RESET 8'h00
`define FL_PROTECT_RESET 8'hFF

// Status register fields
`define FL_BIT_ARMED 0
`define FL_BIT_SETTLED 1
`define FL_BIT_REFUSED 2
`define FL_BIT_RECOVER 3
`define FL_BIT_PUMP 4

// Address geometry
`define FL_PAGE_LSB 9
`define FL_ROW_LSB 6
`define FL_OPTION_ADDR 16'hFFCF
`define FL_VECTOR_BASE 16'hFFD0
`define FL_NO_PROTECT 8'hFF

// Timing, in ns, and derived cycle counts (least times round up)
`define FL_CLK_NS 50
`define FL_TNVS_NS 5000
`define FL_TPAS_NS 10000
`define FL_TRCV_NS 1000
`define FL_TNVS_CYC ((`FL_TNVS_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_TPAS_CYC ((`FL_TPAS_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_TRCV_CYC ((`FL_TRCV_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)

`endif

// file: hw/flash_ctl_pkg.sv
// Types shared by the array controller modules.
// Assumes the constants header is included by the modules that need it.
package flash_ctl_pkg;

  // Sequencer phase, one-hot
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_ARMED = 5'h02,
    PH_SETTLED = 5'h04,
    PH_HV_ON = 5'h08,
    PH_RECOVER = 5'h10
  } phase_type;

  // Operation that the latched target belongs to
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_PAGE_ERASE = 2'h1,
    OP_WHOLE_ERASE = 2'h2
  } op_type;

endpackage

// file: hw/flash_ctl_apb.sv
// APB slave front end of the array controller.
// Assumes a single clock; answers every access with no wait state.
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
module flash_ctl_apb
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Register file side
  output logic wr_ctrl_o,
  output logic wr_prot_o,
  output logic wr_stat_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] ctrl_i,
  input wire logic [7:0] prot_i,
  input wire logic [7:0] stat_i,
  input wire logic [15:0] target_i
);

  logic access;
  logic mapped;
  logic [31:0] rd_mux;

  assign access = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign wdata_o = pwdata_i[7:0];

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      `FL_OFS_CONTROL: rd_mux = {24'h00_0000, ctrl_i};
      `FL_OFS_PROTECT: rd_mux = {24'h00_0000, prot_i};
      `FL_OFS_STATUS: rd_mux = {24'h00_0000, stat_i};
      `FL_OFS_TARGET: rd_mux = {16'h0000, target_i};
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped or misaligned addresses answer with an error, no effect
  assign pslverr_o = access & ~mapped;
  assign wr_ctrl_o = access & pwrite_i & (paddr_i == `FL_OFS_CONTROL);
  assign wr_prot_o = access & pwrite_i & (paddr_i == `FL_OFS_PROTECT);
  assign wr_stat_o = access & pwrite_i & (paddr_i == `FL_OFS_STATUS);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

endmodule

// file: hw/flash_ctl_protect.sv
// Protection window check for a latched target.
// Purely combinational; the caller supplies the latched address and op.
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
module flash_ctl_protect
  import flash_ctl_pkg::*;
(
  input wire logic [7:0] prot_i,
  input wire logic [15:0] addr_i,
  input wire op_type op_i,
  output logic blocked_o
);

  logic [15:0] start;
  logic none;
  logic [15:0] hi;

  // Setting bits 7..1 give address bits 15..9, lower bits zero
  assign start = {prot_i[7:1], 9'h000}; // R21
  assign none = (prot_i == `FL_NO_PROTECT); // R22

  // Highest address touched; the top page holds the vectors, so a unit
  // is fenced when any byte of it reaches FFC0 and up
  always_comb begin
    case (op_i)
      OP_PAGE_ERASE: hi = {addr_i[15:`FL_PAGE_LSB], 9'h1FF};
      OP_PROGRAM: hi = {addr_i[15:`FL_ROW_LSB], 6'h3F};
      default: hi = 16'hFFFF;
    endcase
  end

  // Window runs from the start up to FFFF. The option byte and vectors
  // are fenced for page erase and row programming; only a whole erase
  // may clear them, and that is refused while any window is set.
  always_comb begin
    case (op_i)
      OP_WHOLE_ERASE: blocked_o = ~none; // R18 R19
      default: blocked_o = (~none & (addr_i >= start)) |
        (hi[15:6] == 10'h3FF); // R18 R19 R20 R7
    endcase
  end

endmodule

// file: hw/flash_ctl.sv
// Program and erase sequencer for the embedded nonvolatile array.
// Assumes the array macro applies erase/program while the pump is on.
//
// Behaviour
// [R1] Erased bits read 1; programming only drives chosen bits to 0.
// [R2] Page erase clears a 512-byte aligned page, its smallest unit.
// [R3] High voltage sets only with program or erase and settle done.
// [R4] With erase set, whole select picks full array, else one page.
// [R5] Program and erase never both held or set together.
// [R6] High voltage bit drives the pump and array high voltage.
// [R7] Page erase never clears the 48-byte vector area.
// [R8] Host page erase sequence: set, write, 5us, HV, 20ms, clear.
// [R9] Array write in erase mode selects the target, stores nothing.
// [R10] Host whole erase sequence: set, write, 5us, HV, 200ms, clear.
// [R11] Array reads resume only 1us after high voltage clears.
// [R12] Programming works on 64-byte aligned rows.
// [R13] Program select makes array writes latch address and data.
// [R14] Host row program: set, write, 5us, HV, 10us, bytes 20-40us.
// [R15] Host keeps byte spacing under the maximum program time.
// [R16] Host code must not run from the array being changed.
// [R17] Host keeps step order; unrelated work may interleave.
// [R18] Protected window runs from the setting's start up to FFFF.
// [R19] High voltage refused when the target is protected.
// [R20] Option byte and vectors are always protected; a whole erase still clears them when no window is set.
// [R21] Setting bits 7..1 give start address bits 15..9.
// [R22] Setting of all ones means no window; bit 0 only matters there.
// [R23] Refused high voltage writes are ignored, bit stays clear.
// [R24] Array writes with no mode selected change nothing.
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
module flash_ctl
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // APB register port
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Processor access to the array
  input wire logic ARR_WR_I,
  input wire logic ARR_RD_I,
  input wire logic [15:0] ARR_ADDR_I,
  input wire logic [7:0] ARR_WDATA_I,
  output logic [7:0] ARR_RDATA_O,
  output logic ARR_READY_O,
  // Array macro
  input wire logic [7:0] CELL_RDATA_I,
  output logic PUMP_ON_O,
  output logic CELL_ERASE_O,
  output logic CELL_WHOLE_O,
  output logic [15:0] CELL_TARGET_O,
  output logic CELL_PROG_O,
  output logic [7:0] CELL_CLEAR_MASK_O
);

  localparam logic [8:0] TNVS_CYC = 9'(`FL_TNVS_CYC);
  localparam logic [8:0] TPAS_CYC = 9'(`FL_TPAS_CYC);
  localparam logic [8:0] TRCV_CYC = 9'(`FL_TRCV_CYC);

  function automatic logic [8:0] sat_inc(input logic [8:0] v);
    sat_inc = (v == 9'h1FF) ? v : v + 9'h001;
  endfunction

  function automatic logic same_unit(input logic [15:0] a,
                                     input logic [15:0] b,
                                     input op_type op);
    case (op)
      OP_PROGRAM: same_unit = (a[15:`FL_ROW_LSB] == b[15:`FL_ROW_LSB]);
      default: same_unit = 1'b1;
    endcase
  endfunction

  logic wr_ctrl;
  logic wr_prot;
  logic wr_stat;
  logic [7:0] wdata;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  logic pgm_q;
  logic erase_q;
  logic whole_q;
  logic hv_q;
  logic [7:0] prot_q;
  logic refused_q;
  logic [15:0] target_q;
  op_type op_q;
  op_type op_now;
  phase_type phase_q;
  logic [8:0] cnt_q;
  logic blocked;
  logic hv_req;
  logic hv_ok;
  logic mode_any;
  logic arr_latch;
  logic prog_ok;
  logic both_req;

  ////////////////////////////////////////////////////////////////////////
  // Register access

  flash_ctl_apb u_apb (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .prdata_o(PRDATA_O),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .wr_ctrl_o(wr_ctrl),
    .wr_prot_o(wr_prot),
    .wr_stat_o(wr_stat),
    .wdata_o(wdata),
    .ctrl_i(ctrl_rd),
    .prot_i(prot_q),
    .stat_i(stat_rd),
    .target_i(target_q)
  );

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`FL_BIT_PROGRAM] = pgm_q;
    ctrl_rd[`FL_BIT_ERASE] = erase_q;
    ctrl_rd[`FL_BIT_WHOLE] = whole_q;
    ctrl_rd[`FL_BIT_HV] = hv_q;
    stat_rd = 8'h00;
    stat_rd[`FL_BIT_ARMED] = (phase_q == PH_ARMED);
    stat_rd[`FL_BIT_SETTLED] = (phase_q == PH_SETTLED);
    stat_rd[`FL_BIT_REFUSED] = refused_q;
    stat_rd[`FL_BIT_RECOVER] = (phase_q == PH_RECOVER);
    stat_rd[`FL_BIT_PUMP] = hv_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits

  assign mode_any = pgm_q | erase_q;
  assign both_req = wdata[`FL_BIT_PROGRAM] & wdata[`FL_BIT_ERASE];
  assign hv_req = wr_ctrl & wdata[`FL_BIT_HV] & ~hv_q;
  assign op_now = ~erase_q ? OP_PROGRAM :
    (whole_q ? OP_WHOLE_ERASE : OP_PAGE_ERASE); // R4

  flash_ctl_protect u_protect (
    .prot_i(prot_q),
    .addr_i(target_q),
    .op_i(op_q),
    .blocked_o(blocked)
  );

  // Mode must match the one the target was latched under
  assign hv_ok = mode_any & (phase_q == PH_SETTLED) &
    (op_now == op_q) & ~blocked; // R3 R19

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pgm_q <= 1'b0;
      erase_q <= 1'b0;
      whole_q <= 1'b0;
    end else if (wr_ctrl && !both_req) begin
      // A write asking for both leaves both as they were
      if (wdata[`FL_BIT_PROGRAM] && erase_q) begin
        pgm_q <= 1'b0; // R5
        erase_q <= 1'b0;
      end else if (wdata[`FL_BIT_ERASE] && pgm_q) begin
        pgm_q <= 1'b0; // R5
        erase_q <= 1'b0;
      end else begin
        pgm_q <= wdata[`FL_BIT_PROGRAM];
        erase_q <= wdata[`FL_BIT_ERASE];
      end
      whole_q <= wdata[`FL_BIT_WHOLE];
    end else if (wr_ctrl) begin
      whole_q <= wdata[`FL_BIT_WHOLE];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hv_q <= 1'b0;
    end else if (hv_req && hv_ok) begin
      hv_q <= 1'b1; // R3
    end else if (wr_ctrl && !wdata[`FL_BIT_HV]) begin
      hv_q <= 1'b0; // R23
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prot_q <= `FL_PROTECT_RESET;
    end else if (wr_prot) begin
      prot_q <= wdata;
    end
  end

  // Sticky refusal flag; a new refusal wins over a write-one clear
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      refused_q <= 1'b0;
    end else if (hv_req && !hv_ok) begin
      refused_q <= 1'b1; // R23
    end else if (wr_stat && wdata[`FL_BIT_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer phase and shared timer

  // A write in erase or program setup only names the target
  assign arr_latch = ARR_WR_I & mode_any & ~hv_q &
    (phase_q != PH_RECOVER); // R9 R13 R24

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      target_q <= 16'h0000;
      op_q <= OP_PROGRAM;
    end else if (arr_latch) begin
      target_q <= ARR_ADDR_I;
      op_q <= op_now;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      phase_q <= PH_IDLE;
      cnt_q <= 9'h000;
    end else begin
      case (phase_q)
        PH_IDLE: begin
          cnt_q <= 9'h000;
          if (arr_latch) begin
            phase_q <= PH_ARMED;
          end
        end
        PH_ARMED: begin
          cnt_q <= arr_latch ? 9'h000 : sat_inc(cnt_q);
          if (!mode_any) begin
            phase_q <= PH_IDLE;
          end else if (!arr_latch && cnt_q >= TNVS_CYC - 9'h001) begin
            phase_q <= PH_SETTLED; // R3
          end
        end
        PH_SETTLED: begin
          cnt_q <= 9'h000;
          if (!mode_any) begin
            phase_q <= PH_IDLE;
          end else if (hv_req && hv_ok) begin
            phase_q <= PH_HV_ON;
          end else if (arr_latch) begin
            phase_q <= PH_ARMED;
          end
        end
        PH_HV_ON: begin
          cnt_q <= sat_inc(cnt_q);
          if (!hv_q) begin
            cnt_q <= 9'h000;
            phase_q <= PH_RECOVER;
          end
        end
        PH_RECOVER: begin
          cnt_q <= sat_inc(cnt_q);
          if (cnt_q >= TRCV_CYC - 9'h001) begin
            phase_q <= PH_IDLE; // R11
          end
        end
        default: begin
          phase_q <= PH_IDLE;
          cnt_q <= 9'h000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array macro drive

  assign PUMP_ON_O = hv_q; // R6
  assign CELL_ERASE_O = hv_q & erase_q & (op_q != OP_PROGRAM);
  assign CELL_WHOLE_O = (op_q == OP_WHOLE_ERASE); // R4
  // Page erase target is page aligned so the macro clears 512 bytes
  assign CELL_TARGET_O = (op_q == OP_PAGE_ERASE) ?
    {target_q[15:`FL_PAGE_LSB], 9'h000} : target_q; // R2

  // Bytes are accepted only inside the latched row, after the settle
  assign prog_ok = ARR_WR_I & pgm_q & hv_q & (op_q == OP_PROGRAM) &
    (cnt_q >= TPAS_CYC - 9'h001) &
    same_unit(ARR_ADDR_I, target_q, OP_PROGRAM); // R12 R13

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CELL_PROG_O <= 1'b0;
      CELL_CLEAR_MASK_O <= 8'h00;
    end else begin
      CELL_PROG_O <= prog_ok;
      if (prog_ok) begin
        CELL_CLEAR_MASK_O <= ~ARR_WDATA_I; // R1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  // Reads stall while high voltage is on and through the recovery time
  // The pump-on phase is included so the cycle in which the bit drops
  // does not open a one-cycle read window before recovery starts
  assign ARR_READY_O = ~hv_q & (phase_q != PH_HV_ON) &
    (phase_q != PH_RECOVER); // R11

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ARR_RDATA_O <= 8'hFF;
    end else if (ARR_RD_I && ARR_READY_O) begin
      ARR_RDATA_O <= CELL_RDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_interlock;
    @(posedge CLK_I) disable iff (!RST_B_I)
      !(pgm_q && erase_q);
  endproperty
  a_interlock: assert property (p_interlock) // R5
    else $error("program and erase both set");

  property p_hv_needs_settle;
    @(posedge CLK_I) disable iff (!RST_B_I)
      $rose(hv_q) |-> $past(phase_q) == PH_SETTLED && $past(mode_any);
  endproperty
  a_hv_needs_settle: assert property (p_hv_needs_settle) // R3
    else $error("high voltage set without settled setup");

  property p_settle_time;
    @(posedge CLK_I) disable iff (!RST_B_I)
      $rose(phase_q == PH_SETTLED) |-> $past(cnt_q) >= TNVS_CYC - 9'h001;
  endproperty
  a_settle_time: assert property (p_settle_time) // R3
    else $error("settle shorter than the setup time");

  property p_hv_protect;
    @(posedge CLK_I) disable iff (!RST_B_I)
      $rose(hv_q) |-> !$past(blocked);
  endproperty
  a_hv_protect: assert property (p_hv_protect) // R19
    else $error("high voltage set on protected target");

  property p_refuse_clear;
    @(posedge CLK_I) disable iff (!RST_B_I)
      hv_req && !hv_ok |=> !hv_q && refused_q;
  endproperty
  a_refuse_clear: assert property (p_refuse_clear) // R23
    else $error("refused high voltage write took effect");

  property p_pump;
    @(posedge CLK_I) disable iff (!RST_B_I)
      PUMP_ON_O == hv_q && (!CELL_ERASE_O || PUMP_ON_O);
  endproperty
  a_pump: assert property (p_pump) // R6
    else $error("pump state differs from high voltage bit");

  property p_recovery;
    @(posedge CLK_I) disable iff (!RST_B_I)
      $fell(hv_q) |-> !ARR_READY_O [*7] ##1 !ARR_READY_O [*7] ##1
        !ARR_READY_O [*7] ##1 ARR_READY_O;
  endproperty
  a_recovery: assert property (p_recovery) // R11
    else $error("array read reopened at wrong time");

  property p_vector_page;
    @(posedge CLK_I) disable iff (!RST_B_I)
      CELL_ERASE_O && op_q == OP_PAGE_ERASE |->
        CELL_TARGET_O[15:`FL_PAGE_LSB] != 7'h7F;
  endproperty
  a_vector_page: assert property (p_vector_page) // R7
    else $error("page erase reached the vector page");

  property p_idle_write;
    @(posedge CLK_I) disable iff (!RST_B_I)
      ARR_WR_I && !mode_any |=> !CELL_PROG_O && $stable(target_q);
  endproperty
  a_idle_write: assert property (p_idle_write) // R24
    else $error("array write with no mode had an effect");

  property p_row;
    @(posedge CLK_I) disable iff (!RST_B_I)
      CELL_PROG_O |-> ($past(ARR_ADDR_I) >> 6) == (target_q >> 6);
  endproperty
  a_row: assert property (p_row) // R12
    else $error("byte programmed outside latched row");

endmodule

// file: test/flash_ctl_bench.sv
// Self-checking bench for the program and erase sequencer.
// Assumes the sequencer top with its APB port and array strobes; no model
// of the array macro beyond a driven read-data bus.
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
`define CHK(got_v, exp_v) begin total_checks++; \
  if ((got_v) !== (exp_v)) begin err_total++; \
  $display("mismatch at %0t got %0h expected %0h", \
  $time, (got_v), (exp_v)); end end
module flash_ctl_bench;
  localparam logic [7:0] ctl_ofs = `FL_OFS_CONTROL;
  localparam logic [7:0] prot_ofs = `FL_OFS_PROTECT;
  localparam logic [7:0] stat_ofs = `FL_OFS_STATUS;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic arr_wr, arr_rd, arr_ready, pump_on, cell_erase, cell_whole;
  logic cell_prog, e;
  logic [15:0] arr_addr, cell_target;
  logic [7:0] arr_wdata, arr_rdata, cell_rdata, clear_mask, d;
  int err_total = 0;
  int total_checks = 0;
  int prog_cnt = 0;
  int rec_cnt = 0;
  int n0;

  always #25 clk = ~clk;

  flash_ctl u_flash_ctl (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ARR_WR_I(arr_wr), .ARR_RD_I(arr_rd),
    .ARR_ADDR_I(arr_addr), .ARR_WDATA_I(arr_wdata),
    .ARR_RDATA_O(arr_rdata), .ARR_READY_O(arr_ready),
    .CELL_RDATA_I(cell_rdata), .PUMP_ON_O(pump_on),
    .CELL_ERASE_O(cell_erase), .CELL_WHOLE_O(cell_whole),
    .CELL_TARGET_O(cell_target), .CELL_PROG_O(cell_prog),
    .CELL_CLEAR_MASK_O(clear_mask));

  // Program pulses and read-blocked cycles after the pump drops
  always @(negedge clk) begin
    if (cell_prog === 1'b1) prog_cnt++;
    if (pump_on === 1'b1) rec_cnt = 0;
    else if (arr_ready === 1'b0) rec_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer; psel is dropped and an idle cycle follows it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] r, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] dv);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, {24'h0, dv}, r, er);
  endtask

  task chk(input logic [7:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    `CHK(r, {24'h0, x})
  endtask

  task aw(input logic [15:0] a, input logic [7:0] dv);
    arr_wr <= 1'b1;
    arr_addr <= a;
    arr_wdata <= dv;
    @(posedge clk);
    arr_wr <= 1'b0;
    @(posedge clk);
  endtask

  task ar(input logic [15:0] a);
    arr_rd <= 1'b1;
    arr_addr <= a;
    @(posedge clk);
    arr_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Reference: op 0 row program, 1 page erase, 2 whole erase
  function automatic bit blk(int op, int p, int a);
    int u;
    if (op == 2) return p != 'hFF;
    u = (op == 1) ? (a | 'h1FF) : (a | 'h3F);
    return (u >= 'hFFC0) || (p != 'hFF && a >= ((p & 'hFE) << 8));
  endfunction

  task run_op(input int op, input logic [15:0] a, input logic [7:0] p);
    logic [7:0] m;
    bit ok;
    m = (op == 0) ? 8'h01 : (op == 1) ? 8'h02 : 8'h06;
    ok = !blk(op, p, a);
    wr(prot_ofs, p);
    wr(ctl_ofs, m);
    aw(a, 8'h3C);
    cyc(110);
    wr(ctl_ofs, m | 8'h08);
    `CHK(pump_on, ok)
    chk(ctl_ofs, ok ? (m | 8'h08) : m);
    apb(1'b0, stat_ofs, 32'h0, rv, e);
    `CHK(rv[2], !ok)
    if (ok && op != 0) begin
      `CHK(cell_erase, 1'b1)
      `CHK(cell_whole, op == 2)
    end
    if (ok && op == 1) `CHK(cell_target, a & 16'hFE00)
    wr(stat_ofs, 8'h04);
    wr(ctl_ofs, ok ? 8'h08 : 8'h00);
    wr(ctl_ofs, 8'h00);
    `CHK(pump_on, 1'b0)
    cyc(25);
    if (ok) `CHK(rec_cnt >= 20 && rec_cnt <= 21, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, arr_wr, arr_rd} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    arr_addr = 16'h0000;
    arr_wdata = 8'h00;
    cell_rdata = 8'h00;
    void'($urandom(32'h9b558a12));
    cyc(3);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(ctl_ofs, 8'h00);
    chk(prot_ofs, 8'hFF);
    `CHK(pump_on, 1'b0)
    `CHK(arr_rdata, 8'hFF)
    `CHK(arr_ready, 1'b1)
    apb(1'b1, 8'h10, 32'h0F, rv, e);
    `CHK(e, 1'b1)
    chk(ctl_ofs, 8'h00);
    wr(ctl_ofs, 8'h03);
    chk(ctl_ofs, 8'h00);
    wr(ctl_ofs, 8'h01);
    wr(ctl_ofs, 8'h03);
    chk(ctl_ofs, 8'h01);
    wr(ctl_ofs, 8'h00);
    wr(ctl_ofs, 8'h08);
    chk(ctl_ofs, 8'h00);
    // HV asked for before the settle time has run
    wr(ctl_ofs, 8'h01);
    aw(16'h2000, 8'h00);
    wr(ctl_ofs, 8'h09);
    `CHK(pump_on, 1'b0)
    wr(ctl_ofs, 8'h00);
    wr(stat_ofs, 8'h04);
    n0 = prog_cnt;
    aw(16'h3000, 8'h00);
    cyc(2);
    `CHK(prog_cnt, n0)
    `CHK(cell_target, 16'h2000)
    // Row program of one byte inside the row, with a stray byte outside the row
    wr(ctl_ofs, 8'h01);
    aw(16'h1005, 8'hFF);
    cyc(110);
    wr(ctl_ofs, 8'h09);
    `CHK(pump_on, 1'b1)
    cyc(210);
    d = 8'($urandom);
    aw(16'h1000 | 16'($urandom_range(63)), d);
    cyc(2);
    `CHK(prog_cnt, n0 + 1)
    `CHK(clear_mask, ~d)
    aw(16'h1040, 8'h12);
    cyc(2);
    `CHK(prog_cnt, n0 + 1)
    wr(ctl_ofs, 8'h08);
    wr(ctl_ofs, 8'h00);
    cell_rdata <= 8'h5A;
    ar(16'h1000);
    cyc(1);
    `CHK(arr_rdata, 8'hFF)
    cyc(25);
    d = 8'($urandom);
    cell_rdata <= d;
    ar(16'h1000);
    cyc(1);
    `CHK(arr_rdata, d)
    run_op(1, 16'h23AB, 8'hFF);
    run_op(2, 16'h0860, 8'hFF);
    run_op(2, 16'h0860, 8'hFD);
    run_op(1, 16'hFE10, 8'hFF);
    run_op(0, 16'hFFCF, 8'hFF);
    run_op(0, 16'h0A00, 8'h0B);
    run_op(0, 16'h09FF, 8'h0B);
    run_op(1, 16'h5000, 8'h00);
    for (int i = 0; i < 12; i++) begin
      run_op($urandom_range(2), 16'($urandom),
             $urandom_range(1) ? 8'hFF : 8'($urandom));
    end
    complete_run();
  end
endmodule
